// File: logic/apdc_top.sv
// automatic power-down control: idle counter, power-down mode and input blocking
`timescale 1ns/1ps

module apdc_top (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic addressStrobeInput,
   input wire logic externalClockInput,
   input wire logic chipSelectInput_n,
   input wire logic resetPinInput,
   input wire logic [2:0] controlInput,
   input wire logic dataByteEnableInput,
   input wire logic [7:0] mcuAddrLow,
   input wire logic [7:0] mcuData,
   input wire logic autoPowerDownEnable,
   input wire logic strobePolarity,
   input wire logic portDPin1ClockSelect,
   input wire logic [7:0] powerMgmtRegA,
   input wire logic [7:0] powerMgmtRegB,
   output logic powerDownFlag,
   output logic [3:0] idleCount,
   output logic memorySelect,
   output logic memoryStandby,
   output logic ioBlockSelect,
   output logic [7:0] memAddrLow,
   output logic [7:0] memData,
   output logic [7:0] pldAddrLow,
   output logic [2:0] pldControl,
   output logic pldStrobe,
   output logic pldDataByteEnable,
   output logic pldAndClock,
   output logic macrocellClock,
   output logic pldTurboOff,
   output logic ioHoldLevels,
   output logic addrOutDefined,
   output logic dataPortEnable,
   output logic peripheralEnable
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [7:0] pinRaw;
   logic [7:0] pinSync;
   logic [7:0] addrSync;
   logic [7:0] dataSync;

   assign pinRaw = {dataByteEnableInput, controlInput, resetPinInput,
                    chipSelectInput_n, externalClockInput, addressStrobeInput};

   apdc_sync #(.WIDTH(apdc_pkg::PIN_WIDTH)) syncPins (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pinIn(pinRaw),
      .syncOut(pinSync)
   );

   apdc_sync #(.WIDTH(apdc_pkg::ADDR_WIDTH)) syncAddr (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pinIn(mcuAddrLow),
      .syncOut(addrSync)
   );

   apdc_sync #(.WIDTH(apdc_pkg::ADDR_WIDTH)) syncData (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pinIn(mcuData),
      .syncOut(dataSync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic strobePrev;
      logic clockPrev;
      logic [3:0] count;
      logic powerDown;
      logic memorySelect;
      logic memoryStandby;
      logic ioBlockSelect;
      logic [7:0] memAddrLow;
      logic [7:0] memData;
      logic [7:0] pldAddrLow;
      logic [2:0] pldControl;
      logic pldStrobe;
      logic pldDbe;
      logic pldAndClock;
      logic macrocellClock;
      logic turboOff;
      logic ioHold;
      logic addrOutDefined;
      logic dataPortEnable;
      logic peripheralEnable;
   } apdc_state_type;

   localparam apdc_state_type STATE_RESET = '{
      strobePrev: 1'b0,
      clockPrev: 1'b0,
      count: apdc_pkg::COUNT_RESET,
      powerDown: 1'b0,
      memorySelect: 1'b0,
      memoryStandby: 1'b1,
      ioBlockSelect: 1'b0,
      memAddrLow: apdc_pkg::BUS_RESET,
      memData: apdc_pkg::BUS_RESET,
      pldAddrLow: apdc_pkg::BUS_RESET,
      pldControl: apdc_pkg::CTRL_RESET,
      pldStrobe: 1'b0,
      pldDbe: 1'b0,
      pldAndClock: 1'b0,
      macrocellClock: 1'b0,
      turboOff: 1'b0,
      ioHold: 1'b0,
      addrOutDefined: 1'b1,
      dataPortEnable: 1'b1,
      peripheralEnable: 1'b1
   };

   apdc_state_type state;
   apdc_state_type next_state;

   logic strobeNow;
   logic clockNow;
   logic strobeToggle;
   logic clockRise;
   logic strobeIdle;
   logic wakeRequest;
   logic selectLow;
   logic pd;

   // clock pin only drives counter, AND array clock and macrocells when configured as clock
   assign strobeNow = pinSync[apdc_pkg::PIN_STROBE];
   assign clockNow = pinSync[apdc_pkg::PIN_CLOCK] & portDPin1ClockSelect;
   assign strobeToggle = strobeNow ^ state.strobePrev;
   assign clockRise = clockNow & ~state.clockPrev;
   assign selectLow = ~pinSync[apdc_pkg::PIN_SELECT_N];
   // idle means parked at the selected level with no edge this cycle
   assign strobeIdle = (strobeNow == strobePolarity) & ~strobeToggle;
   assign wakeRequest = selectLow | pinSync[apdc_pkg::PIN_RESET];

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      next_state = state;
      next_state.strobePrev = strobeNow;
      next_state.clockPrev = clockNow;

      // idle counter and power-down flag
      if (!autoPowerDownEnable) begin
         next_state.count = apdc_pkg::COUNT_RESET;
         next_state.powerDown = 1'b0;
      end else if (strobeToggle || wakeRequest) begin
         // a waking event restarts a full idle period
         next_state.count = apdc_pkg::COUNT_RESET;
         next_state.powerDown = 1'b0;
      end else if (strobeIdle && clockRise && state.count != apdc_pkg::IDLE_LIMIT) begin
         // counter sees the pin clock masked by portDPin1ClockSelect, never the PLD-gated copy
         next_state.count = state.count + 4'h1;
         if (state.count == apdc_pkg::IDLE_LIMIT - 4'h1) begin
            next_state.powerDown = 1'b1;
         end
      end

      pd = next_state.powerDown;

      // memories: standby in power-down or when deselected
      next_state.memorySelect = selectLow & ~pd;
      next_state.memoryStandby = ~selectLow | pd;
      next_state.ioBlockSelect = selectLow;

      // bus blocked toward memories in power-down; zeros stop memory wake-ups
      next_state.memAddrLow = pd ? apdc_pkg::BUS_RESET : addrSync;
      next_state.memData = pd ? apdc_pkg::BUS_RESET : dataSync;

      // PLD AND array inputs: power-down blocks only the low address, register b blocks each
      next_state.pldAddrLow = (pd | powerMgmtRegB[apdc_pkg::PMB_ADDR_LOW_BLOCK])
                              ? apdc_pkg::BUS_RESET : addrSync;
      for (int i = 0; i < apdc_pkg::CTRL_COUNT; i++) begin
         next_state.pldControl[i] = pinSync[apdc_pkg::PIN_CTRL0 + i]
                                    & ~powerMgmtRegB[apdc_pkg::PMB_CTRL0_BLOCK + i];
      end
      next_state.pldStrobe = strobeNow
                             & ~powerMgmtRegB[apdc_pkg::PMB_STROBE_BLOCK];
      next_state.pldDbe = pinSync[apdc_pkg::PIN_DBE]
                          & ~powerMgmtRegB[apdc_pkg::PMB_DBE_BLOCK];

      // clock gating is software's job even in power-down, hence no pd term here
      next_state.pldAndClock = clockNow
                               & ~powerMgmtRegA[apdc_pkg::PMA_CLK_AND_BLOCK];
      next_state.macrocellClock = clockNow
                                  & ~powerMgmtRegA[apdc_pkg::PMA_CLK_MCELL_BLOCK];

      // PLD speed follows the turbo bit alone
      next_state.turboOff = powerMgmtRegA[apdc_pkg::PMA_TURBO_OFF];

      // port behaviour while powered down
      next_state.ioHold = pd;
      next_state.addrOutDefined = ~pd;
      next_state.dataPortEnable = ~pd;
      next_state.peripheralEnable = ~pd;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= STATE_RESET;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, each a field of the state register

   assign powerDownFlag = state.powerDown;
   assign idleCount = state.count;
   assign memorySelect = state.memorySelect;
   assign memoryStandby = state.memoryStandby;
   assign ioBlockSelect = state.ioBlockSelect;
   assign memAddrLow = state.memAddrLow;
   assign memData = state.memData;
   assign pldAddrLow = state.pldAddrLow;
   assign pldControl = state.pldControl;
   assign pldStrobe = state.pldStrobe;
   assign pldDataByteEnable = state.pldDbe;
   assign pldAndClock = state.pldAndClock;
   assign macrocellClock = state.macrocellClock;
   assign pldTurboOff = state.turboOff;
   assign ioHoldLevels = state.ioHold;
   assign addrOutDefined = state.addrOutDefined;
   assign dataPortEnable = state.dataPortEnable;
   assign peripheralEnable = state.peripheralEnable;

endmodule

// File: shared/apdc_pkg.sv
// constants shared by the automatic power-down control block
package apdc_pkg;

   // idle counter
   localparam int unsigned COUNT_WIDTH = 4;
   localparam logic [3:0] IDLE_LIMIT = 4'hF;
   localparam logic [3:0] COUNT_RESET = 4'h0;

   // power_mgmt_reg_a bit positions
   localparam int unsigned PMA_TURBO_OFF = 3;
   localparam int unsigned PMA_CLK_AND_BLOCK = 4;
   localparam int unsigned PMA_CLK_MCELL_BLOCK = 5;

   // power_mgmt_reg_b bit positions
   localparam int unsigned PMB_ADDR_LOW_BLOCK = 0;
   localparam int unsigned PMB_CTRL0_BLOCK = 2;
   localparam int unsigned PMB_STROBE_BLOCK = 5;
   localparam int unsigned PMB_DBE_BLOCK = 6;

   // layout of the synchronised pin vector
   localparam int unsigned PIN_WIDTH = 8;
   localparam int unsigned PIN_STROBE = 0;
   localparam int unsigned PIN_CLOCK = 1;
   localparam int unsigned PIN_SELECT_N = 2;
   localparam int unsigned PIN_RESET = 3;
   localparam int unsigned PIN_CTRL0 = 4;
   localparam int unsigned PIN_DBE = 7;
   localparam int unsigned CTRL_COUNT = 3;

   // bus widths
   localparam int unsigned ADDR_WIDTH = 8;
   localparam logic [7:0] BUS_RESET = 8'h00;
   localparam logic [2:0] CTRL_RESET = 3'h0;

endpackage

// File: logic/apdc_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps

module apdc_sync #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stageOne;

   // first stage feeds only the second; each bit is a separate level
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stageOne <= '0;
         syncOut <= '0;
      end else begin
         stageOne <= pinIn;
         syncOut <= stageOne;
      end
   end

endmodule

// File: test/apdc_assertions.sv
// port assertions for the automatic power-down control
`timescale 1ns/1ps
module apdc_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic addressStrobeInput,
   input wire logic chipSelectInput_n,
   input wire logic resetPinInput,
   input wire logic autoPowerDownEnable,
   input wire logic [7:0] powerMgmtRegA,
   input wire logic powerDownFlag,
   input wire logic [3:0] idleCount,
   input wire logic memorySelect,
   input wire logic memoryStandby,
   input wire logic [7:0] memData,
   input wire logic pldAndClock,
   input wire logic macrocellClock,
   input wire logic pldTurboOff,
   input wire logic ioHoldLevels,
   input wire logic dataPortEnable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // pins pass two sync stages, so pin-driven checks allow up to three edges
   AST_FLAG_FULL: assert property (powerDownFlag |-> idleCount == 4'hF)
      else $error("flag before full count");
   AST_CNT_STEP: assert property (idleCount != $past(idleCount) |->
      idleCount == $past(idleCount) + 4'h1 || idleCount == 4'h0)
      else $error("count jumped");
   AST_OFF: assert property (!autoPowerDownEnable |=> idleCount == 4'h0 && !powerDownFlag)
      else $error("counting while off");
   AST_STROBE: assert property ($changed(addressStrobeInput) |-> ##[1:3] idleCount == 4'h0)
      else $error("toggle kept count");
   AST_CSEL: assert property ((!chipSelectInput_n)[*4] |-> !powerDownFlag)
      else $error("asleep with select low");
   AST_PIN: assert property (resetPinInput[*4] |-> !powerDownFlag)
      else $error("asleep with reset pin high");
   AST_MEM: assert property (powerDownFlag |-> !memorySelect && memoryStandby && memData == 8'h00)
      else $error("memory not blocked");
   AST_PORTS: assert property (ioHoldLevels == powerDownFlag && dataPortEnable == !powerDownFlag)
      else $error("port state wrong");
   AST_TURBO: assert property ($stable(powerMgmtRegA[3])[*3] |-> pldTurboOff == powerMgmtRegA[3])
      else $error("turbo bit not followed");
   AST_CLKCUT: assert property (powerMgmtRegA[4][*3] |-> !pldAndClock)
      else $error("clock reached and array");
   AST_MCELL: assert property (powerMgmtRegA[5][*3] |-> !macrocellClock)
      else $error("clock reached macrocells");
   // main scenarios
   cover property (powerDownFlag);
   cover property ($fell(powerDownFlag));
   cover property (idleCount == 4'hE ##1 idleCount == 4'hF);
endmodule

// File: test/apdc_mcu_model.sv
// bus-side model: address strobe activity and the external clock pin
`timescale 1ns/1ps
module apdc_mcu_model (
   input wire logic core_clk,
   input wire logic idle,
   input wire logic idleLevel,
   input wire logic [3:0] halfPeriod,
   output logic strobe,
   output logic extClk,
   output int rises
);
   logic [2:0] cyc = 3'h0;
   logic [3:0] t = 4'h0;
   initial begin
      strobe = 1'b0;
      extClk = 1'b0;
      rises = 0;
   end
   ////////////////////////////////////////
   // awake: strobe pulses, clock still; asleep: clock runs from low, so
   // every rise counted is one seen after the strobe settled
   always @(posedge core_clk) begin
      cyc <= cyc + 3'h1;
      if (!idle) begin
         strobe <= cyc[2];
         extClk <= 1'b0;
         t <= 4'h0;
         rises <= 0;
      end else begin
         strobe <= idleLevel;
         t <= t + 4'h1;
         if (t == halfPeriod - 4'h1) begin
            t <= 4'h0;
            extClk <= ~extClk;
            if (!extClk) rises <= rises + 1;
         end
      end
   end
endmodule

// File: test/auto_power_down_control_bench.sv
// randomised bench for the automatic power-down control
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module auto_power_down_control_bench;
   logic core_clk = 1'b0, rst_n = 1'b0, idle = 1'b0, pol = 1'b0, en = 1'b0;
   logic csN = 1'b1, rstPin = 1'b0, dbe = 1'b0, strobe, extClk;
   logic clkSel = 1'b1, lvl = 1'b0;
   logic pStb, pDbe, mClk, ioHold, aDef, perEn;
   logic [2:0] pCtl;
   logic [3:0] cnt;
   logic [2:0] ctl = 3'h0;
   logic [3:0] hp = 4'h4;
   logic [7:0] adr = 8'h00, dat = 8'h00, regA = 8'h00, regB = 8'h00;
   logic pd, mSel, mStby, ioSel, turbo, dpEn;
   logic [7:0] mAdr, mDat, pAdr;
   int rises, bad_count = 0, n_tests = 0;
   always #10 core_clk = ~core_clk;
   apdc_mcu_model mcu (.core_clk(core_clk), .idle(idle), .idleLevel(lvl),
      .halfPeriod(hp), .strobe(strobe), .extClk(extClk), .rises(rises));
   apdc_top uut (.core_clk(core_clk), .rst_n(rst_n), .addressStrobeInput(strobe),
      .externalClockInput(extClk), .chipSelectInput_n(csN), .resetPinInput(rstPin),
      .controlInput(ctl), .dataByteEnableInput(dbe), .mcuAddrLow(adr), .mcuData(dat),
      .autoPowerDownEnable(en), .strobePolarity(pol), .portDPin1ClockSelect(clkSel),
      .powerMgmtRegA(regA), .powerMgmtRegB(regB), .powerDownFlag(pd), .idleCount(cnt),
      .memorySelect(mSel), .memoryStandby(mStby), .ioBlockSelect(ioSel),
      .memAddrLow(mAdr), .memData(mDat), .pldAddrLow(pAdr), .pldControl(pCtl),
      .pldStrobe(pStb), .pldDataByteEnable(pDbe), .pldAndClock(), .macrocellClock(mClk),
      .pldTurboOff(turbo), .ioHoldLevels(ioHold), .addrOutDefined(aDef),
      .dataPortEnable(dpEn), .peripheralEnable(perEn));
   ////////////////////////////////////////
   // expected low address at the and array
   function automatic logic [7:0] expAddr(input logic blk, input logic [7:0] a);
      return blk ? 8'h00 : a;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one sleep cycle: awake checks, idle until asleep or 17 rises, then wake;
   // s routes the clock pin in, m parks the strobe at the counting level
   task automatic trial(input bit e, input bit c, input bit s, input bit m);
      int i;
      logic p;
      logic seen;
      p = 1'($urandom);
      seen = 1'b0;
      @(posedge core_clk);
      en <= e;
      csN <= c;
      clkSel <= s;
      pol <= p;
      lvl <= m ? p : ~p;
      hp <= 4'h4 + 4'($urandom % 4);
      regA <= 8'($urandom);
      regB <= 8'($urandom);
      adr <= 8'($urandom);
      dat <= 8'($urandom);
      ctl <= 3'($urandom);
      dbe <= 1'($urandom);
      tick(12);
      #1;
      `CHK("mem addr", adr, mAdr)
      `CHK("mem data awake", dat, mDat)
      `CHK("pld addr", expAddr(regB[0], adr), pAdr)
      `CHK("pld control", ctl & ~regB[4:2], pCtl)
      `CHK("pld dbe", dbe & ~regB[6], pDbe)
      `CHK("turbo", regA[3], turbo)
      `CHK("mem select", !c, mSel)
      `CHK("io select", !c, ioSel)
      `CHK("addr out awake", 1'b1, aDef)
      `CHK("periph awake", 1'b1, perEn)
      @(posedge core_clk);
      idle <= 1'b1;
      for (i = 0; i < 400 && pd !== 1'b1 && rises < 17; i++) begin
         tick(1);
         #1;
         if (mClk === 1'b1) seen = 1'b1;
      end
      `CHK("power down", e & c & s & m, pd)
      `CHK("pld strobe", lvl & ~regB[5], pStb)
      `CHK("mcell clock", s & ~regA[5], seen)
      if (pd === 1'b1) begin
         `CHK("idle rises", 15, rises)
         `CHK("idle count", 4'hF, cnt)
         `CHK("io hold", 1'b1, ioHold)
         `CHK("addr out asleep", 1'b0, aDef)
         `CHK("periph asleep", 1'b0, perEn)
         `CHK("mem data", 8'h00, mDat)
         `CHK("standby", 1'b1, mStby)
         `CHK("data port", 1'b0, dpEn)
         `CHK("turbo asleep", regA[3], turbo)
      end
      @(posedge core_clk);
      regA[4] <= 1'b1; // software gates the pld clock while asleep
      case ($urandom % 3)
         0: idle <= 1'b0;
         1: csN <= 1'b0;
         default: rstPin <= 1'b1;
      endcase
      tick(10);
      #1;
      `CHK("awake", 1'b0, pd)
      @(posedge core_clk);
      rstPin <= 1'b0;
      idle <= 1'b0;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // corner cases first: asleep, disabled, held selected, clock pin not routed, strobe parked off level; then random
   initial begin
      void'($urandom(32864));
      tick(8);
      rst_n <= 1'b1;
      tick(3);
      trial(1'b1, 1'b1, 1'b1, 1'b1);
      trial(1'b0, 1'b1, 1'b1, 1'b1);
      trial(1'b1, 1'b0, 1'b1, 1'b1);
      trial(1'b1, 1'b1, 1'b0, 1'b1);
      trial(1'b1, 1'b1, 1'b1, 1'b0);
      repeat (16) trial(1'($urandom), 1'($urandom), ($urandom % 4) != 0, ($urandom % 4) != 0);
      finish_test();
   end
   // watchdog well past the longest run of trials
   initial begin
      #400000;
      bad_count++;
      finish_test();
   end
endmodule
bind apdc_top apdc_assertions chk (.*);
